// *** rtl/cel_top.sv ***
// module: top of the comparator event and interrupt logic
//
// Function
// (R1) Three comparator channels, each configured and flagged independently.
// (R2) Each channel result goes to a pin output and is software-readable.
// (R3) Status bits 2:0 show the three results, read-only.
// (R4) Control bit 5 inverts the channel result, used for detection too.
// (R5) Control bits 4:3 select which transitions set the channel flag.
// (R6) Select 00 never sets the flag.
// (R7) Select 01 sets on rising, 10 on falling adjusted result.
// (R8) Select 11 sets on every change of the adjusted result.
// (R9) A set flag stays until software writes zero; hardware never clears.
// (R10) Software writing 1 to a flag sets it like a real event.
// (R11) Flags in bits 2:0 of flag register, enables in bits 2:0.
// (R12) Request needs flag, channel enable, peripheral bit 6, global bit 7.
// (R13) Flags set on events regardless of any enables.
// (R14) Software tracks earlier status reads to tell which change occurred.
// (R15) Results synchronised, transitions found against previous clock value.
`timescale 1ns/100ps
module cel_top #(
   parameter int unsigned NUM_CHANNELS = cel_pkg::NUM_CHANNELS
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // analog comparator outputs
   input  wire logic [NUM_CHANNELS-1:0] comp_raw_i,
   // channel control registers, one write strobe each
   input  wire logic [NUM_CHANNELS-1:0] ctrl_wr_i,
   input  wire logic [7:0]              ctrl_wdata_i,
   // peripheral flag register write
   input  wire logic                    flag_wr_i,
   input  wire logic [7:0]              flag_wdata_i,
   // peripheral enable register write
   input  wire logic                    enable_wr_i,
   input  wire logic [7:0]              enable_wdata_i,
   // irq control register write
   input  wire logic                    irqctl_wr_i,
   input  wire logic [7:0]              irqctl_wdata_i,
   // register read-back
   output logic      [8*NUM_CHANNELS-1:0] channel_control_reg_o,
   output logic      [7:0]              output_status_reg_o,
   output logic      [7:0]              peripheral_flag_reg_o,
   output logic      [7:0]              peripheral_enable_reg_o,
   output logic      [7:0]              irq_control_reg_o,
   // pin results and interrupt request
   output logic      [NUM_CHANNELS-1:0] channel_result_o,
   output logic                         irq_o
);

   // flag and enable fields hold three bits at most
   if (NUM_CHANNELS < 1 || NUM_CHANNELS > 3) begin : g_bad_count
      $error("cel_top: NUM_CHANNELS must be 1 to 3");
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [7:0]              ctrl [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] invert;
   logic [2*NUM_CHANNELS-1:0] evsel;
   logic [NUM_CHANNELS-1:0] channel_event_enable;
   logic                    peripheral_irq_enable;
   logic                    global_irq_enable;
   logic [NUM_CHANNELS-1:0] channel_event_flag;

   genvar g;
   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_ctl
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               ctrl[g] <= cel_pkg::CTRL_RESET;
            end else if (ctrl_wr_i[g]) begin
               ctrl[g] <= ctrl_wdata_i; // R1
            end
         end
         assign invert[g] = ctrl[g][cel_pkg::INVERT_BIT]; // R4
         assign evsel[2*g+1:2*g] =
            ctrl[g][cel_pkg::EVSEL_HI:cel_pkg::EVSEL_LO]; // R5
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         channel_event_enable <= NUM_CHANNELS'(cel_pkg::ENABLE_RESET);
      end else if (enable_wr_i) begin
         channel_event_enable <= enable_wdata_i[NUM_CHANNELS-1:0]; // R11
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         peripheral_irq_enable <= 1'b0;
         global_irq_enable     <= 1'b0;
      end else if (irqctl_wr_i) begin
         peripheral_irq_enable <= irqctl_wdata_i[cel_pkg::PERIPH_EN_BIT];
         global_irq_enable     <= irqctl_wdata_i[cel_pkg::GLOBAL_EN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // detection and flags
   // ---------------------------------------------------------------
   cel_chan_if #(.N(NUM_CHANNELS)) chan ();

   cel_detect #(.N(NUM_CHANNELS)) u_detect (
      .clk_i    (clk_i),
      .rst_b_i  (rst_b_i),
      .raw_i    (comp_raw_i),
      .invert_i (invert),
      .evsel_i  (evsel),
      .chan     (chan.src)
   );

   cel_flags #(.N(NUM_CHANNELS)) u_flags (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .chan    (chan.dst),
      .wr_i    (flag_wr_i),
      .wdata_i (flag_wdata_i[NUM_CHANNELS-1:0]),
      .flag_o  (channel_event_flag)
   );

   // ---------------------------------------------------------------
   // outputs, all registered
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         channel_result_o    <= '0;
         output_status_reg_o <= 8'h00;
      end else begin
         channel_result_o    <= chan.result; // R2
         output_status_reg_o <= 8'(chan.result); // R3
      end
   end

   // one cycle behind the flag; a gated level, not a pulse
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (|(channel_event_flag & channel_event_enable))
                  & peripheral_irq_enable & global_irq_enable; // R12
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         peripheral_flag_reg_o   <= 8'h00;
         peripheral_enable_reg_o <= 8'h00;
         irq_control_reg_o       <= 8'h00;
      end else begin
         peripheral_flag_reg_o   <= 8'(channel_event_flag); // R11
         peripheral_enable_reg_o <= 8'(channel_event_enable);
         irq_control_reg_o       <= {global_irq_enable,
                                     peripheral_irq_enable, 6'h00};
      end
   end

   generate
      for (g = 0; g < NUM_CHANNELS; g++) begin : g_rb
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               channel_control_reg_o[8*g+7:8*g] <= 8'h00;
            end else begin
               channel_control_reg_o[8*g+7:8*g] <= ctrl[g];
            end
         end
      end
   endgenerate

endmodule : cel_top

// *** common/cel_pkg.sv ***
// package: constants and types for the comparator event logic
package cel_pkg;

   // ---------------------------------------------------------------
   // channel count and field layout
   // ---------------------------------------------------------------
   localparam int unsigned NUM_CHANNELS     = 3;
   localparam int unsigned CTRL_WIDTH       = 8;
   localparam int unsigned INVERT_BIT       = 5;
   localparam int unsigned EVSEL_LO         = 3;
   localparam int unsigned EVSEL_HI         = 4;
   localparam int unsigned STATUS_LO        = 0;
   localparam int unsigned STATUS_HI        = 2;
   localparam int unsigned PERIPH_EN_BIT    = 6;
   localparam int unsigned GLOBAL_EN_BIT    = 7;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam logic [2:0]  FLAG_RESET       = 3'h0;
   localparam logic [2:0]  ENABLE_RESET     = 3'h0;
   localparam logic [1:0]  SYNC_RESET       = 2'h0;

   // ---------------------------------------------------------------
   // event selection codes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CEL_EV_NONE    = 2'h0,
      CEL_EV_RISE    = 2'h1,
      CEL_EV_FALL    = 2'h2,
      CEL_EV_ANY     = 2'h3
   } cel_evsel_t;

endpackage : cel_pkg

// *** common/cel_chan_if.sv ***
// interface: per-channel adjusted result and event pulse
`timescale 1ns/100ps
interface cel_chan_if #(
   parameter int unsigned N = 3
);
   logic [N-1:0] result;
   logic [N-1:0] event_hit;

   modport src (
      output result,
      output event_hit
   );
   modport dst (
      input  result,
      input  event_hit
   );
endinterface : cel_chan_if

// *** rtl/cel_detect.sv ***
// module: synchroniser, polarity and transition detection per channel
`timescale 1ns/100ps
module cel_detect #(
   parameter int unsigned N = 3
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // raw comparator outputs and configuration
   input  wire logic [N-1:0] raw_i,
   input  wire logic [N-1:0] invert_i,
   input  wire logic [2*N-1:0] evsel_i,
   // results out
   cel_chan_if.src           chan
);

   // refused at elaboration, before any logic is built
   if (N < 1) begin : g_bad_n
      $error("cel_detect: N must be at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic [1:0] sync;
         logic       adj;
         logic       adj_prev;
         logic       rise;
         logic       fall;
         cel_pkg::cel_evsel_t sel;

         // -----------------------------------------------------------
         // two-stage synchroniser; stage 0 feeds only stage 1
         // -----------------------------------------------------------
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               sync <= cel_pkg::SYNC_RESET;
            end else begin
               sync <= {sync[0], raw_i[g]}; // R15
            end
         end

         assign adj = sync[1] ^ invert_i[g]; // R4

         // previous value; a polarity flip looks like a transition,
         // which matches swapping the comparator inputs
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               adj_prev <= 1'b0;
            end else begin
               adj_prev <= adj; // R15
            end
         end

         assign rise = adj & ~adj_prev;
         assign fall = ~adj & adj_prev;
         assign sel  = cel_pkg::cel_evsel_t'(evsel_i[2*g+1:2*g]); // R5

         always_comb begin
            unique case (sel)
               cel_pkg::CEL_EV_NONE: chan.event_hit[g] = 1'b0; // R6
               cel_pkg::CEL_EV_RISE: chan.event_hit[g] = rise; // R7
               cel_pkg::CEL_EV_FALL: chan.event_hit[g] = fall; // R7
               cel_pkg::CEL_EV_ANY:  chan.event_hit[g] = rise | fall; // R8
            endcase
         end

         assign chan.result[g] = adj;
      end
   endgenerate

endmodule : cel_detect

// *** rtl/cel_flags.sv ***
// module: sticky per-channel event flags with software write
`timescale 1ns/100ps
module cel_flags #(
   parameter int unsigned N = 3
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   // events in
   cel_chan_if.dst           chan,
   // software write to the flag register
   input  wire logic         wr_i,
   input  wire logic [N-1:0] wdata_i,
   // flags out
   output logic      [N-1:0] flag_o
);

   // refused at elaboration, before any logic is built
   if (N < 1) begin : g_bad_n
      $error("cel_flags: N must be at least 1");
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_fl
         // ---------------------------------------------------------
         // event wins over a same-cycle software clear
         // ---------------------------------------------------------
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               flag_o[g] <= 1'b0;
            end else if (chan.event_hit[g]) begin
               flag_o[g] <= 1'b1; // R13
            end else if (wr_i) begin
               flag_o[g] <= wdata_i[g]; // R9 R10
            end
         end
      end
   endgenerate

endmodule : cel_flags

// *** sim/cel_top_props.sv ***
// checker: port-level properties of the comparator event logic
`timescale 1ns/100ps
module cel_top_props #(
   parameter int unsigned NUM_CHANNELS = 3
) (
   // clock, reset and stimulus seen at the ports
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   input  wire logic [NUM_CHANNELS-1:0]   comp_raw_i,
   input  wire logic [NUM_CHANNELS-1:0]   ctrl_wr_i,
   input  wire logic [7:0]                ctrl_wdata_i,
   input  wire logic                      flag_wr_i,
   input  wire logic [7:0]                flag_wdata_i,
   // outputs under watch
   input  wire logic [8*NUM_CHANNELS-1:0] channel_control_reg_o,
   input  wire logic [7:0]                output_status_reg_o,
   input  wire logic [7:0]                peripheral_flag_reg_o,
   input  wire logic [7:0]                peripheral_enable_reg_o,
   input  wire logic [7:0]                irq_control_reg_o,
   input  wire logic [NUM_CHANNELS-1:0]   channel_result_o,
   input  wire logic                      irq_o
);
   logic [2:0] inv;
   logic [1:0] sel0;
   logic [2:0] pf;
   assign inv  = {channel_control_reg_o[21], channel_control_reg_o[13],
                  channel_control_reg_o[5]};
   assign sel0 = channel_control_reg_o[4:3];
   assign pf   = peripheral_flag_reg_o[2:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // lone strobe, so no later write overtakes the readback
   sequence s_pulse(w);
      w ##1 !w;
   endsequence
   a_status_mirror: assert property (
      output_status_reg_o == {5'h00, channel_result_o})
      else $error("status bits differ from results");
   a_result_path: assert property (
      $past(rst_b_i, 3) |-> channel_result_o == ($past(comp_raw_i, 3) ^ inv))
      else $error("result does not follow raw input");
   a_ctrl_readback: assert property (
      s_pulse(ctrl_wr_i[0]) |=> channel_control_reg_o[7:0]
                                == $past(ctrl_wdata_i, 2))
      else $error("control readback wrong");
   a_rise_sets: assert property (
      $rose(channel_result_o[0]) && sel0 == 2'h1 |=> pf[0])
      else $error("rising edge did not set flag");
   a_any_sets: assert property (
      $changed(channel_result_o[0]) && sel0 == 2'h3 |=> pf[0])
      else $error("change did not set flag");
   a_none_quiet: assert property (
      $rose(pf[0]) && sel0 == 2'h0 && $past(sel0) == 2'h0
      |-> $past(flag_wr_i, 2))
      else $error("flag set with events off");
   a_flag_sticky: assert property (
      |($past(pf) & ~pf) |-> $past(flag_wr_i, 2))
      else $error("flag cleared without a write");
   a_sw_write: assert property (
      s_pulse(flag_wr_i) |=> (pf & $past(flag_wdata_i[2:0], 2))
                             == $past(flag_wdata_i[2:0], 2))
      else $error("written one did not set flag");
   a_irq_gate: assert property (
      irq_o == (|(pf & peripheral_enable_reg_o[2:0])
                && irq_control_reg_o[6] && irq_control_reg_o[7]))
      else $error("request gating wrong");
endmodule : cel_top_props
bind cel_top cel_top_props #(.NUM_CHANNELS(NUM_CHANNELS)) props_u (
   .clk_i                   (clk_i),
   .rst_b_i                 (rst_b_i),
   .comp_raw_i              (comp_raw_i),
   .ctrl_wr_i               (ctrl_wr_i),
   .ctrl_wdata_i            (ctrl_wdata_i),
   .flag_wr_i               (flag_wr_i),
   .flag_wdata_i            (flag_wdata_i),
   .channel_control_reg_o   (channel_control_reg_o),
   .output_status_reg_o     (output_status_reg_o),
   .peripheral_flag_reg_o   (peripheral_flag_reg_o),
   .peripheral_enable_reg_o (peripheral_enable_reg_o),
   .irq_control_reg_o       (irq_control_reg_o),
   .channel_result_o        (channel_result_o),
   .irq_o                   (irq_o)
);

// *** sim/cel_comp_model.sv ***
// model: analog comparator cores driving raw decisions
`timescale 1ns/100ps
module cel_comp_model #(
   parameter int unsigned N = 3
) (
   // requested decisions
   input  wire logic [N-1:0] decide_i,
   // raw levels toward the event logic
   output wire logic [N-1:0] comp_raw_o
);
   // settling off the clock grid, so the synchroniser sees async edges
   assign #17 comp_raw_o = decide_i;
endmodule : cel_comp_model

// *** sim/tb.sv ***
// testbench: comparator event logic driven through its plain ports
`timescale 1ns/100ps
module tb;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [2:0]  decide = 3'h0;
   wire  logic [2:0] comp_raw;
   logic [2:0]  ctrl_wr = 3'h0;
   logic        flag_wr = 1'b0, enable_wr = 1'b0, irqctl_wr = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [23:0] ctrl_q;
   logic [7:0]  status_q, flag_q, enable_q, irqctl_q;
   logic [2:0]  result_q;
   logic        irq_q;
   int          n_fail = 0;
   int          total_checks = 0;
   cel_comp_model #(.N(3)) model_u (.decide_i(decide), .comp_raw_o(comp_raw));
   cel_top #(.NUM_CHANNELS(3)) dut_u (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .comp_raw_i(comp_raw),
      .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(wdata),
      .flag_wr_i(flag_wr), .flag_wdata_i(wdata),
      .enable_wr_i(enable_wr), .enable_wdata_i(wdata),
      .irqctl_wr_i(irqctl_wr), .irqctl_wdata_i(wdata),
      .channel_control_reg_o(ctrl_q), .output_status_reg_o(status_q),
      .peripheral_flag_reg_o(flag_q), .peripheral_enable_reg_o(enable_q),
      .irq_control_reg_o(irqctl_q), .channel_result_o(result_q),
      .irq_o(irq_q));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask : idle
   // k: 0 control, 1 flags, 2 enables, 3 irq control
   task automatic wr(input int k, input logic [7:0] d,
                     input logic [2:0] ch = 3'h0);
      wdata = d;
      ctrl_wr = (k == 0) ? ch : 3'h0;
      flag_wr = (k == 1);
      enable_wr = (k == 2);
      irqctl_wr = (k == 3);
      idle(1);
      {flag_wr, enable_wr, irqctl_wr} = 3'h0;
      ctrl_wr = 3'h0;
      idle(3);
   endtask : wr
   task automatic t_events();
      logic [2:0] ch;
      logic [2:0] seen;
      // twelve steps, so every channel meets every select code
      for (int s = 0; s < 12; s++) begin
         ch = 3'h1 << (s % 3);
         wr(0, 8'((s % 4) << 3), ch);
         wr(1, 8'h00);
         seen = status_q[2:0];
         decide = decide | ch;
         idle(5);
         chk(|(flag_q[2:0] & ch), s[0]);
         chk({result_q, status_q}, {ch, 5'h00, ch});
         chk(seen ^ status_q[2:0], ch);
         wr(1, 8'h00);
         seen = status_q[2:0];
         decide = decide & ~ch;
         idle(5);
         chk(|(flag_q[2:0] & ch), s[1]);
         chk(seen & ~status_q[2:0], ch);
      end
      $display("test events done");
   endtask : t_events
   task automatic t_invert();
      wr(1, 8'h00);
      wr(0, 8'h28, 3'h2);
      idle(2);
      chk({ctrl_q[15:8], result_q, status_q}, {8'h28, 3'h2, 8'h02});
      chk(flag_q, 8'h02);
      wr(1, 8'h00);
      decide = 3'h2;
      idle(5);
      chk({result_q, flag_q}, 11'h000);
      decide = 3'h0;
      wr(0, 8'hc7, 3'h4);
      chk(ctrl_q[23:16], 8'hc7);
      $display("test invert done");
   endtask : t_invert
   task automatic t_irq();
      wr(1, 8'hff);
      chk({flag_q, irq_q}, {8'h07, 1'b0});
      wr(2, 8'h02);
      wr(3, 8'h40);
      chk(irq_q, 1'b0);
      wr(3, 8'h80);
      chk(irq_q, 1'b0);
      wr(3, 8'hc0);
      chk({irqctl_q, enable_q, irq_q}, {8'hc0, 8'h02, 1'b1});
      wr(1, 8'h05);
      chk(irq_q, 1'b0);
      idle(20);
      chk(flag_q, 8'h05);
      wr(2, 8'h04);
      chk(irq_q, 1'b1);
      wr(1, 8'h00);
      chk({flag_q, irq_q}, 9'h000);
      $display("test irq done");
   endtask : t_irq
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard, far beyond the planned run
   initial begin
      #2000000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      #5;
      rst_b_i = 1'b1;
      idle(1);
      chk({ctrl_q, status_q, flag_q}, 40'h0);
      $display("test reset done");
      t_events();
      t_invert();
      t_irq();
      print_verdict();
   end
endmodule : tb
